// ==== logic/ptc_config_top.sv ====
/*
 * Pixel timing and test pattern configuration bank with Avalon-MM slave.
 * Assumes line sync and false lock arrive asynchronously from pins; host writes baselines after power-up.
 */
// Operation
// - Clamp rise index 0-63 sets clamp pulse start; used only in double sampling.
// - Clamp fall index 0-63 sets clamp pulse end; used only in double sampling.
// - Sample rise index 0-63 sets sampling pulse start in every mode.
// - Sample fall index 0-63 sets sampling pulse end.
// - Three-bit input clock band, codes 000-101; 110 and 111 never written.
// - Two-bit loop band 10, 01, 00; code 11 is reserved, never written.
// - Writing one to loop control bit 0 resets the loop, then self-clears.
// - Sixteen-bit pattern offset: pixels from line sync edge to valid region.
// - Sixteen-bit pattern span: width of valid region in pixels.
// - Pattern switch bit 7 picks converted data or generated test patterns.
// - Pattern mode: fixed, horizontal gradient, vertical gradient, lattice.
// - Modes 100 stripe, 101 synchronous, 110 asynchronous test; 111 unused.
// - Pseudo-random enable bit 3 overrides the pattern switch.
// - Read-only status bit 0 reports loop false lock at half frequency.
// - Hold enable bit selects sample-and-hold; clear selects double sampling.
`timescale 1ns/1ps
module ptc_config_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Avalon-MM slave
    input wire logic [ptc_pkg::PTC_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [ptc_pkg::PTC_DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [ptc_pkg::PTC_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Pins
    input wire logic line_sync_input_i,
    input wire logic false_lock_i,
    // Timing outputs
    output logic black_level_pulse_o,
    output logic sample_pulse_o,
    output logic [ptc_pkg::PTC_PHASE_W-1:0] pixel_phase_o,
    output logic loop_reset_o,
    output logic hold_mode_o,
    output logic [2:0] clock_band_o,
    output logic [1:0] loop_band_o,
    // Test pattern outputs
    output logic [1:0] pattern_source_o,
    output logic [2:0] pattern_mode_o,
    output logic pattern_valid_o,
    // Interrupt
    output logic irq_o
);
    import ptc_pkg::*;

    logic rst_meta_reg;
    logic rst_n;
    logic ack_reg;
    logic [PTC_IDX_W-1:0] bus_idx;
    logic bus_word;
    logic bus_wr;
    logic [7:0] wbyte;
    logic [7:0] rd_next;
    logic [PTC_PHASE_W-1:0] clamp_rise_reg;
    logic [PTC_PHASE_W-1:0] clamp_fall_reg;
    logic [PTC_PHASE_W-1:0] sample_rise_reg;
    logic [PTC_PHASE_W-1:0] sample_fall_reg;
    logic [2:0] band_reg;
    logic [1:0] loop_band_reg;
    logic hold_reg;
    logic loop_rst_reg;
    logic [PTC_PIX_W-1:0] offset_reg;
    logic [PTC_PIX_W-1:0] span_reg;
    logic switch_reg;
    logic prbs_reg;
    logic [2:0] mode_reg;
    logic [2:0] sync_reg;
    logic line_filt_reg;
    logic [2:0] lock_sync_reg;
    logic lock_filt_reg;
    logic line_start;
    logic lock_rise;
    logic pixel_tick;
    logic [PTC_PIX_W-1:0] pix_cnt_reg;
    logic in_region;
    logic valid_reg;
    logic [PTC_EV_W-1:0] ev_set;
    logic [PTC_EV_W-1:0] irq_status_reg;
    logic [PTC_EV_W-1:0] irq_mask_reg;
    ptc_src_t src_reg;

    // Reset release through two flops
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Bus decode: one wait state; a write is taken on the edge after ack, read data is latched on the edge that sets ack
    assign bus_idx = avs_address_i[7:2];
    assign bus_word = (avs_address_i[1:0] == 2'b00);
    assign bus_wr = avs_write_i && ack_reg && avs_byteenable_i[0] && bus_word;
    assign wbyte = avs_writedata_i[7:0];
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;

    function automatic logic wr_hit(input logic [5:0] idx);
        wr_hit = bus_wr && (bus_idx == idx);
    endfunction

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
        end
    end

    // Read mux; unused bits and unmapped words read zero
    always_comb begin
        rd_next = 8'h00;
        if (bus_word) begin
            unique case (bus_idx)
                PTC_IDX_HOLD_MODE: rd_next[PTC_HOLD_EN_BIT] = hold_reg;
                PTC_IDX_STATUS: rd_next[PTC_FALSE_LOCK_BIT] = lock_filt_reg;
                PTC_IDX_CLAMP_RISE: rd_next[5:0] = clamp_rise_reg;
                PTC_IDX_CLAMP_FALL: rd_next[5:0] = clamp_fall_reg;
                PTC_IDX_SAMPLE_RISE: rd_next[5:0] = sample_rise_reg;
                PTC_IDX_SAMPLE_FALL: rd_next[5:0] = sample_fall_reg;
                PTC_IDX_CLOCK_BAND: rd_next = {1'b0, band_reg, 2'b00, loop_band_reg};
                PTC_IDX_LOOP_CTRL: rd_next[PTC_LOOP_RST_BIT] = loop_rst_reg;
                PTC_IDX_OFFSET_HI: rd_next = offset_reg[15:8];
                PTC_IDX_OFFSET_LO: rd_next = offset_reg[7:0];
                PTC_IDX_SPAN_HI: rd_next = span_reg[15:8];
                PTC_IDX_SPAN_LO: rd_next = span_reg[7:0];
                PTC_IDX_PAT_CTRL: rd_next = {switch_reg, mode_reg, prbs_reg, 3'b000};
                PTC_IDX_IRQ_STATUS: rd_next[PTC_EV_W-1:0] = irq_status_reg;
                PTC_IDX_IRQ_MASK: rd_next[PTC_EV_W-1:0] = irq_mask_reg;
                default: rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack_reg) begin
            avs_readdata_o <= {24'h000000, rd_next};
        end
    end

    // Edge position registers; bits 7:6 are dropped
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clamp_rise_reg <= PTC_RST_CLAMP_RISE;
            clamp_fall_reg <= PTC_RST_CLAMP_FALL;
            sample_rise_reg <= PTC_RST_SAMPLE_RISE;
            sample_fall_reg <= PTC_RST_SAMPLE_FALL;
        end else begin
            if (wr_hit(PTC_IDX_CLAMP_RISE)) clamp_rise_reg <= wbyte[5:0];
            if (wr_hit(PTC_IDX_CLAMP_FALL)) clamp_fall_reg <= wbyte[5:0];
            if (wr_hit(PTC_IDX_SAMPLE_RISE)) sample_rise_reg <= wbyte[5:0];
            if (wr_hit(PTC_IDX_SAMPLE_FALL)) sample_fall_reg <= wbyte[5:0];
        end
    end

    // Bands: an illegal code is dropped so the loop never sees it
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            band_reg <= PTC_RST_BAND;
            loop_band_reg <= PTC_RST_LOOP_BAND;
            hold_reg <= PTC_RST_HOLD_EN;
        end else begin
            if (wr_hit(PTC_IDX_CLOCK_BAND) && wbyte[PTC_BAND_LSB +: 3] <= PTC_BAND_LAST) begin
                band_reg <= wbyte[PTC_BAND_LSB +: 3];
            end
            if (wr_hit(PTC_IDX_CLOCK_BAND) && wbyte[PTC_LOOP_BAND_LSB +: 2] != PTC_LOOP_BAND_RSVD) begin
                loop_band_reg <= wbyte[PTC_LOOP_BAND_LSB +: 2];
            end
            if (wr_hit(PTC_IDX_HOLD_MODE)) hold_reg <= wbyte[PTC_HOLD_EN_BIT];
        end
    end

    // Loop reset stands one cycle, then clears itself
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            loop_rst_reg <= 1'b0;
        end else begin
            loop_rst_reg <= wr_hit(PTC_IDX_LOOP_CTRL) && wbyte[PTC_LOOP_RST_BIT];
        end
    end

    // Pattern region and control
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            offset_reg <= PTC_RST_PIX16;
            span_reg <= PTC_RST_PIX16;
            switch_reg <= 1'b0;
            prbs_reg <= 1'b0;
            mode_reg <= PTC_RST_MODE;
        end else begin
            if (wr_hit(PTC_IDX_OFFSET_HI)) offset_reg[15:8] <= wbyte;
            if (wr_hit(PTC_IDX_OFFSET_LO)) offset_reg[7:0] <= wbyte;
            if (wr_hit(PTC_IDX_SPAN_HI)) span_reg[15:8] <= wbyte;
            if (wr_hit(PTC_IDX_SPAN_LO)) span_reg[7:0] <= wbyte;
            if (wr_hit(PTC_IDX_PAT_CTRL)) begin
                switch_reg <= wbyte[PTC_PAT_SWITCH_BIT];
                prbs_reg <= wbyte[PTC_PRBS_BIT];
                if (wbyte[PTC_PAT_MODE_LSB +: 3] != PTC_MODE_UNUSED) begin
                    mode_reg <= wbyte[PTC_PAT_MODE_LSB +: 3];
                end
            end
        end
    end

    // Source select: pseudo-random wins over the switch
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            src_reg <= PTC_SRC_CONVERTED;
        end else if (prbs_reg) begin
            src_reg <= PTC_SRC_PRBS;
        end else if (switch_reg) begin
            src_reg <= PTC_SRC_PROGRAMMED;
        end else begin
            src_reg <= PTC_SRC_CONVERTED;
        end
    end

    // Pin inputs: a change counts once stages two and three agree
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg <= 3'h0;
            line_filt_reg <= 1'b0;
            lock_sync_reg <= 3'h0;
            lock_filt_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], line_sync_input_i};
            lock_sync_reg <= {lock_sync_reg[1:0], false_lock_i};
            if (sync_reg[1] == sync_reg[2]) line_filt_reg <= sync_reg[2];
            if (lock_sync_reg[1] == lock_sync_reg[2]) lock_filt_reg <= lock_sync_reg[2];
        end
    end

    assign line_start = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !line_filt_reg;
    assign lock_rise = (lock_sync_reg[1] == lock_sync_reg[2]) && lock_sync_reg[2] && !lock_filt_reg;

    // Pixel count from the line sync leading edge; saturates on long lines
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pix_cnt_reg <= '1;
        end else if (line_start) begin
            pix_cnt_reg <= '0;
        end else if (pixel_tick && pix_cnt_reg != 16'hffff) begin
            pix_cnt_reg <= PTC_PIX_W'(pix_cnt_reg + 16'h0001);
        end
    end

    assign in_region = (pix_cnt_reg >= offset_reg)
        && ({1'b0, pix_cnt_reg} < 17'({1'b0, offset_reg} + {1'b0, span_reg}));

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= in_region;
        end
    end

    // Interrupts: set wins over a write-one clear
    assign ev_set = {in_region && !valid_reg, line_start, lock_rise};

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
        end else begin
            if (wr_hit(PTC_IDX_IRQ_MASK)) irq_mask_reg <= wbyte[PTC_EV_W-1:0];
            if (wr_hit(PTC_IDX_IRQ_STATUS)) begin
                irq_status_reg <= (irq_status_reg & ~wbyte[PTC_EV_W-1:0]) | ev_set;
            end else begin
                irq_status_reg <= irq_status_reg | ev_set;
            end
        end
    end

    assign irq_o = |(irq_status_reg & irq_mask_reg);

    ptc_edge_gen u_edge (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .loop_reset_i(loop_rst_reg),
        .hold_mode_i(hold_reg),
        .clamp_rise_i(clamp_rise_reg),
        .clamp_fall_i(clamp_fall_reg),
        .sample_rise_i(sample_rise_reg),
        .sample_fall_i(sample_fall_reg),
        .phase_o(pixel_phase_o),
        .pixel_tick_o(pixel_tick),
        .black_level_pulse_o(black_level_pulse_o),
        .sample_pulse_o(sample_pulse_o)
    );

    assign loop_reset_o = loop_rst_reg;
    assign hold_mode_o = hold_reg;
    assign clock_band_o = band_reg;
    assign loop_band_o = loop_band_reg;
    assign pattern_source_o = src_reg;
    assign pattern_mode_o = mode_reg;
    assign pattern_valid_o = valid_reg;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    band_legal_a: assert property (clock_band_o <= 3'h5)
        else $error("input clock band holds an unused code");
    loop_band_legal_a: assert property (loop_band_o != 2'h3)
        else $error("loop band holds the reserved code");
    loop_self_clear_a: assert property (loop_reset_o |=> !loop_reset_o)
        else $error("loop reset did not clear itself");
    region_start_a: assert property (pattern_valid_o |-> $past(pix_cnt_reg) >= $past(offset_reg))
        else $error("valid region before its offset");
    region_width_a: assert property (pattern_valid_o
        |-> {1'b0, $past(pix_cnt_reg)} < 17'({1'b0, $past(offset_reg)} + {1'b0, $past(span_reg)}))
        else $error("valid region wider than its span");
    switch_source_a: assert property (!prbs_reg |=> pattern_source_o == ($past(switch_reg) ? 2'h1 : 2'h0))
        else $error("pattern switch did not pick the source");
    mode_write_a: assert property (bus_wr && bus_idx == PTC_IDX_PAT_CTRL && wbyte[6:4] != 3'h7
        |=> pattern_mode_o == $past(wbyte[6:4])) else $error("pattern mode write lost");
    mode_unused_a: assert property (pattern_mode_o != 3'h7)
        else $error("unused pattern mode taken");
    prbs_priority_a: assert property (prbs_reg |=> pattern_source_o == 2'h2)
        else $error("pseudo-random enable did not win");
    lock_status_a: assert property (avs_read_i && !ack_reg && bus_word && bus_idx == PTC_IDX_STATUS
        |=> avs_readdata_o[0] == $past(lock_filt_reg)) else $error("false lock status misread");
    unused_zero_a: assert property (avs_read_i && !ack_reg && bus_word && bus_idx == PTC_IDX_CLAMP_RISE
        |=> avs_readdata_o[31:6] == 26'h0000000) else $error("unused bits read nonzero");
    bus_answer_a: assert property ((avs_read_i || avs_write_i) && !ack_reg |=> !avs_waitrequest_o)
        else $error("bus request not answered in one cycle");

    line_start_c: cover property (line_start ##[1:300] pattern_valid_o);
    loop_reset_c: cover property (loop_reset_o ##1 pixel_phase_o == 6'h00);
    irq_c: cover property (!irq_o ##1 irq_o);
    prbs_c: cover property (prbs_reg && switch_reg);
endmodule

// ==== logic/ptc_edge_gen.sv ====
/*
 * Pixel phase counter and clamp / sample pulse generator.
 * Assumes one core clock step is one sixty-fourth of a pixel period.
 */
`timescale 1ns/1ps
module ptc_edge_gen (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Settings
    input wire logic loop_reset_i,
    input wire logic hold_mode_i,
    input wire logic [ptc_pkg::PTC_PHASE_W-1:0] clamp_rise_i,
    input wire logic [ptc_pkg::PTC_PHASE_W-1:0] clamp_fall_i,
    input wire logic [ptc_pkg::PTC_PHASE_W-1:0] sample_rise_i,
    input wire logic [ptc_pkg::PTC_PHASE_W-1:0] sample_fall_i,
    // Timing outputs
    output logic [ptc_pkg::PTC_PHASE_W-1:0] phase_o,
    output logic pixel_tick_o,
    output logic black_level_pulse_o,
    output logic sample_pulse_o
);
    import ptc_pkg::*;

    logic [PTC_PHASE_W-1:0] phase_reg;

    // Window with wrap; equal edges give no pulse
    function automatic logic in_window(input logic [5:0] ph, input logic [5:0] rise, input logic [5:0] fall);
        in_window = (rise <= fall) ? (ph >= rise && ph < fall) : (ph >= rise || ph < fall);
    endfunction

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_reg <= '0;
        end else if (loop_reset_i) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= PTC_PHASE_W'(phase_reg + 6'h01);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            black_level_pulse_o <= 1'b0;
            sample_pulse_o <= 1'b0;
        end else begin
            // Clamp idles low in sample-and-hold mode
            black_level_pulse_o <= !hold_mode_i && in_window(phase_reg, clamp_rise_i, clamp_fall_i);
            sample_pulse_o <= in_window(phase_reg, sample_rise_i, sample_fall_i);
        end
    end

    assign phase_o = phase_reg;
    assign pixel_tick_o = (phase_reg == 6'h3f);

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    clamp_rise_a: assert property (phase_reg == clamp_rise_i && clamp_rise_i != clamp_fall_i && !hold_mode_i
        |=> black_level_pulse_o) else $error("clamp pulse did not rise");
    clamp_fall_a: assert property (phase_reg == clamp_fall_i |=> !black_level_pulse_o)
        else $error("clamp pulse did not fall");
    sample_rise_a: assert property (phase_reg == sample_rise_i && sample_rise_i != sample_fall_i
        |=> sample_pulse_o) else $error("sample pulse did not rise");
    sample_fall_a: assert property (phase_reg == sample_fall_i |=> !sample_pulse_o)
        else $error("sample pulse did not fall");
    hold_no_clamp_a: assert property (hold_mode_i |=> !black_level_pulse_o)
        else $error("clamp pulse in sample-and-hold mode");
    phase_step_a: assert property (rst_n_i && !loop_reset_i |=> phase_reg == 6'($past(phase_reg) + 6'h01))
        else $error("pixel phase did not advance by one");
    phase_restart_a: assert property (loop_reset_i |=> phase_reg == 6'h00)
        else $error("loop reset did not restart the phase");
endmodule

// ==== shared/ptc_pkg.sv ====
/*
 * Constants for the pixel timing and test pattern configuration bank.
 * Assumes 8-bit registers, each at word index (byte address / 4) on a 32-bit bus.
 */
package ptc_pkg;
    localparam int PTC_ADDR_W = 8;
    localparam int PTC_DATA_W = 32;
    localparam int PTC_IDX_W = 6;
    localparam int PTC_PHASE_W = 6;
    localparam int PTC_PIX_W = 16;
    localparam int PTC_EV_W = 3;

    // Register indices
    localparam logic [5:0] PTC_IDX_HOLD_MODE = 6'h06;
    localparam logic [5:0] PTC_IDX_STATUS = 6'h07;
    localparam logic [5:0] PTC_IDX_CLAMP_RISE = 6'h20;
    localparam logic [5:0] PTC_IDX_CLAMP_FALL = 6'h21;
    localparam logic [5:0] PTC_IDX_SAMPLE_RISE = 6'h22;
    localparam logic [5:0] PTC_IDX_SAMPLE_FALL = 6'h23;
    localparam logic [5:0] PTC_IDX_CLOCK_BAND = 6'h25;
    localparam logic [5:0] PTC_IDX_LOOP_CTRL = 6'h28;
    localparam logic [5:0] PTC_IDX_OFFSET_HI = 6'h30;
    localparam logic [5:0] PTC_IDX_OFFSET_LO = 6'h31;
    localparam logic [5:0] PTC_IDX_SPAN_HI = 6'h32;
    localparam logic [5:0] PTC_IDX_SPAN_LO = 6'h33;
    localparam logic [5:0] PTC_IDX_PAT_CTRL = 6'h34;
    localparam logic [5:0] PTC_IDX_IRQ_STATUS = 6'h3e;
    localparam logic [5:0] PTC_IDX_IRQ_MASK = 6'h3f;

    // Field positions
    localparam int PTC_HOLD_EN_BIT = 7;
    localparam int PTC_FALSE_LOCK_BIT = 0;
    localparam int PTC_BAND_LSB = 4;
    localparam int PTC_LOOP_BAND_LSB = 0;
    localparam int PTC_LOOP_RST_BIT = 0;
    localparam int PTC_PAT_SWITCH_BIT = 7;
    localparam int PTC_PAT_MODE_LSB = 4;
    localparam int PTC_PRBS_BIT = 3;

    // Legal code limits
    localparam logic [2:0] PTC_BAND_LAST = 3'h5;
    localparam logic [1:0] PTC_LOOP_BAND_RSVD = 2'h3;
    localparam logic [2:0] PTC_MODE_UNUSED = 3'h7;

    // Reset values
    localparam logic [5:0] PTC_RST_CLAMP_RISE = 6'h08;
    localparam logic [5:0] PTC_RST_CLAMP_FALL = 6'h1c;
    localparam logic [5:0] PTC_RST_SAMPLE_RISE = 6'h28;
    localparam logic [5:0] PTC_RST_SAMPLE_FALL = 6'h3c;
    localparam logic [2:0] PTC_RST_BAND = 3'h0;
    localparam logic [1:0] PTC_RST_LOOP_BAND = 2'h2;
    localparam logic PTC_RST_HOLD_EN = 1'b1;
    localparam logic [15:0] PTC_RST_PIX16 = 16'h0000;
    localparam logic [2:0] PTC_RST_MODE = 3'h0;

    // Event bits
    localparam int PTC_EV_FALSE_LOCK = 0;
    localparam int PTC_EV_LINE_START = 1;
    localparam int PTC_EV_REGION = 2;

    typedef enum logic [1:0] {
        PTC_SRC_CONVERTED,
        PTC_SRC_PROGRAMMED,
        PTC_SRC_PRBS
    } ptc_src_t;
endpackage

// ==== verif/ptc_host_model.sv ====
/*
 * Host controller model: Avalon-MM master for the configuration bank.
 * Assumes each transfer is started just after a rising clock edge.
 */
`timescale 1ns/1ps
module ptc_host_model (
    // Bus
    input wire logic clk_i,
    input wire logic [31:0] rdata_i,
    input wire logic wait_i,
    output logic [7:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [31:0] wdata_o
);
    initial begin
        addr_o = 8'h00;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 32'h0;
    end
    // Illegal band codes are sent only when a refusal is wanted
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        addr_o <= a;
        wdata_o <= {24'h0, d};
        rd_o <= !w;
        wr_o <= w;
        @(posedge clk_i);
        // No cycle limit of its own; the bench timeout ends a hung wait
        while (wait_i !== 1'b0) begin
            @(posedge clk_i);
        end
        q = rdata_i[7:0];
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// ==== verif/tb.sv ====
/*
 * Self-checking bench for the configuration bank.
 * Assumes one register per bus word and a host model on the bus.
 */
`timescale 1ns/1ps
module tb;
    import ptc_pkg::*;
    logic clk, nrst, ls, fl, rd, wr, wreq, clamp, samp, lrst, pval, irq, hold;
    logic [5:0] phase;
    logic [7:0] addr, q;
    logic [31:0] wd, rdata;
    logic [2:0] band, mode;
    logic [1:0] lband, src;
    int errors, tests_run, cycles, lpulses, nc, ns;
    ptc_host_model u_host (.clk_i(clk), .rdata_i(rdata), .wait_i(wreq), .addr_o(addr), .rd_o(rd), .wr_o(wr),
        .wdata_o(wd));
    ptc_config_top u_dut (.core_clk_i(clk), .nrst_i(nrst), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'h1), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .line_sync_input_i(ls), .false_lock_i(fl), .black_level_pulse_o(clamp),
        .sample_pulse_o(samp), .pixel_phase_o(phase), .loop_reset_o(lrst), .hold_mode_o(hold), .clock_band_o(band),
        .loop_band_o(lband), .pattern_source_o(src), .pattern_mode_o(mode), .pattern_valid_o(pval), .irq_o(irq));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        lpulses += (lrst === 1'b1);
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Extra edge lets registered outputs follow the new setting
    task automatic wr8(input logic [5:0] i, input logic [7:0] d);
        u_host.xfer(1'b1, {i, 2'b00}, d, q);
        @(posedge clk);
    endtask
    task automatic rd8(input logic [5:0] i, input logic [7:0] exp);
        u_host.xfer(1'b0, {i, 2'b00}, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic pulses();
        nc = 0;
        ns = 0;
        repeat (64) begin
            @(posedge clk);
            nc += (clamp === 1'b1);
            ns += (samp === 1'b1);
        end
    endtask
    task automatic t_reset_values();
        rd8(PTC_IDX_CLAMP_RISE, 8'h08);
        rd8(PTC_IDX_CLAMP_FALL, 8'h1c);
        rd8(PTC_IDX_SAMPLE_RISE, 8'h28);
        rd8(PTC_IDX_SAMPLE_FALL, 8'h3c);
        rd8(PTC_IDX_CLOCK_BAND, 8'h02);
        rd8(PTC_IDX_HOLD_MODE, 8'h80);
        rd8(6'h0f, 8'h00);
    endtask
    task automatic t_edges();
        wr8(PTC_IDX_HOLD_MODE, 8'h00);
        chk(hold, 1'b0);
        pulses();
        chk(nc, 20);
        chk(ns, 20);
        wr8(PTC_IDX_CLAMP_RISE, 8'hc4);
        rd8(PTC_IDX_CLAMP_RISE, 8'h04);
        wr8(PTC_IDX_SAMPLE_FALL, 8'h10);
        pulses();
        chk(nc, 24);
        chk(ns, 40);
        wr8(PTC_IDX_HOLD_MODE, 8'h80);
        pulses();
        chk(nc, 0);
        chk(ns, 40);
    endtask
    task automatic t_band_loop();
        wr8(PTC_IDX_CLOCK_BAND, 8'hd1);
        rd8(PTC_IDX_CLOCK_BAND, 8'h51);
        chk({band, lband}, 5'h15);
        wr8(PTC_IDX_CLOCK_BAND, 8'h63);
        rd8(PTC_IDX_CLOCK_BAND, 8'h51);
        lpulses = 0;
        wr8(PTC_IDX_LOOP_CTRL, 8'h01);
        chk(lpulses, 1);
        chk(phase, 8'h00);
        rd8(PTC_IDX_LOOP_CTRL, 8'h00);
    endtask
    task automatic t_pattern();
        for (int m = 0; m < 7; m++) begin
            wr8(PTC_IDX_PAT_CTRL, 8'h80 | 8'(m << 4));
            chk(mode, 32'(m));
            chk(src, PTC_SRC_PROGRAMMED);
        end
        wr8(PTC_IDX_PAT_CTRL, 8'hf0);
        rd8(PTC_IDX_PAT_CTRL, 8'he0);
        wr8(PTC_IDX_PAT_CTRL, 8'h8f);
        chk(src, PTC_SRC_PRBS);
        rd8(PTC_IDX_PAT_CTRL, 8'h88);
        wr8(PTC_IDX_PAT_CTRL, 8'h00);
        chk(src, PTC_SRC_CONVERTED);
    endtask
    task automatic t_region();
        int n;
        wr8(PTC_IDX_OFFSET_LO, 8'h02);
        wr8(PTC_IDX_SPAN_LO, 8'h03);
        rd8(PTC_IDX_OFFSET_HI, 8'h00);
        ls <= 1'b1;
        repeat (8) @(posedge clk);
        ls <= 1'b0;
        n = 0;
        repeat (700) begin
            @(posedge clk);
            n += (pval === 1'b1);
        end
        chk(n, 192);
        fl <= 1'b1;
        repeat (10) @(posedge clk);
        rd8(PTC_IDX_STATUS, 8'h01);
        rd8(PTC_IDX_IRQ_STATUS, 8'h07);
        chk(irq, 1'b0);
        wr8(PTC_IDX_IRQ_MASK, 8'h01);
        chk(irq, 1'b1);
        wr8(PTC_IDX_IRQ_STATUS, 8'h07);
        chk(irq, 1'b0);
    endtask
    initial begin
        nrst = 1'b0;
        ls = 1'b0;
        fl = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset_values();
        t_edges();
        t_band_loop();
        t_pattern();
        t_region();
        end_of_test();
    end
endmodule
